/* hdl/esq_pkg.sv */
`default_nettype none
package esq_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_OUT  = 12;
  localparam int unsigned NUM_TYPE = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned QMS_NS        = 250000;                  // Quarter millisecond
  localparam int unsigned QMS_US        = 250;
  localparam int unsigned QMS_CYCLES    = QMS_NS / CLK_PERIOD_NS;  // Cycles per quarter ms
  // Group delay per three-bit code, in microseconds
  localparam int unsigned GRP_DLY_US [8] = '{250, 500, 1000, 1500, 2000, 2500, 3000, 5000};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned TYPE_MSB = 5;
  localparam int unsigned GRP_LSB  = 0;
  localparam int unsigned GRP_MSB  = 3;
  localparam int unsigned ON_LSB   = 0;
  localparam int unsigned ON_MSB   = 2;
  localparam int unsigned OFF_LSB  = 4;
  localparam int unsigned OFF_MSB  = 6;
  localparam int unsigned SEL_BIT  = 1;
  localparam int unsigned SWEN_BIT = 0;

  // ****************************************
  // Group codes and rail type codes
  // ****************************************
  localparam logic [3:0] GRP_FIRST   = 4'h0;
  localparam logic [3:0] GRP_LAST    = 4'hE;
  localparam logic [3:0] GRP_DISABLE = 4'hF;
  localparam logic [1:0] RAIL_A      = 2'h0;
  localparam logic [1:0] RAIL_U      = 2'h1;
  localparam logic [1:0] RAIL_S      = 2'h2;
  localparam logic [1:0] RAIL_SX     = 2'h3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SLOT_ADDR [NUM_OUT] = '{8'hF4, 8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hF9,
                                                 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'h7D};
  localparam logic [7:0] CTL_ADDR [NUM_OUT]  = '{8'h56, 8'h57, 8'h5B, 8'h5C, 8'h5D, 8'h69,
                                                 8'h68, 8'h64, 8'h62, 8'h6B, 8'h6C, 8'h6D};
  localparam logic [7:0] TIM_ADDR [NUM_TYPE] = '{8'hC3, 8'hC4, 8'hD3, 8'hD4};
  localparam logic [7:0] STAT_ADDR  = 8'h80;
  localparam logic [7:0] PINLO_ADDR = 8'h81;
  localparam logic [7:0] PINHI_ADDR = 8'h82;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] SLOT_RST  = 8'h0F;
  localparam logic [7:0] TIM_RST   = 8'h22;
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] SLOT_MASK = 8'h3F;
  localparam logic [7:0] TIM_MASK  = 8'h77;
  localparam logic [7:0] CTL_MASK  = 8'h03;

  // Quarter-ms units for a delay code
  function automatic logic [4:0] dly_units(input logic [2:0] code);
    dly_units = 5'(GRP_DLY_US[code] / QMS_US);
  endfunction

endpackage : esq_pkg
`default_nettype wire

/* hdl/esq_step_if.sv */
`default_nettype none
interface esq_step_if;
  logic       start_on;
  logic       start_off;
  logic [2:0] on_code;
  logic [2:0] off_code;
  logic       busy;
  logic       step;
  logic       dir_on;
  logic [3:0] grp;

  modport ctrl    (output start_on, start_off, on_code, off_code,
                   input  busy, step, dir_on, grp);
  modport stepper (input  start_on, start_off, on_code, off_code,
                   output busy, step, dir_on, grp);
endinterface : esq_step_if
`default_nettype wire

/* hdl/esq_group_stepper.sv */
`default_nettype none
module esq_group_stepper
  import esq_pkg::*;
#(
  parameter int unsigned QMS_CYC = QMS_CYCLES
) (
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  // Link to the controller
  esq_step_if.stepper    sif
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic {ST_IDLE, ST_WAIT} esq_stp_st_t;

  typedef struct packed {
    esq_stp_st_t state;
    logic        dir_on;
    logic [3:0]  grp;
    logic        step;
    logic [4:0]  units;
    logic [15:0] tick;
  } esq_stp_t;

  esq_stp_t s_r;
  esq_stp_t s_nxt;

  // Walk group indices with the type's delay between neighbours
  always_comb begin
    s_nxt      = s_r;
    s_nxt.step = 1'b0;
    if (sif.start_on || sif.start_off) begin
      // Turn-off request wins when both arrive together
      s_nxt.state  = ST_WAIT;
      s_nxt.dir_on = !sif.start_off;
      s_nxt.grp    = sif.start_off ? GRP_LAST : GRP_FIRST;                 // R10
      s_nxt.step   = 1'b1;
      s_nxt.tick   = 16'h0000;
      s_nxt.units  = dly_units(sif.start_off ? sif.off_code : sif.on_code);
    end else begin
      case (s_r.state)
        ST_IDLE: begin
          s_nxt.tick = 16'h0000;
        end
        ST_WAIT: begin
          if (s_r.tick == 16'(QMS_CYC - 1)) begin
            s_nxt.tick = 16'h0000;
            if (s_r.units == 5'h01) begin
              // Delay over: handle the next consecutive index
              s_nxt.grp   = s_r.dir_on ? s_r.grp + 4'h1 : s_r.grp - 4'h1;  // R4 R10
              s_nxt.step  = 1'b1;
              s_nxt.units = dly_units(s_r.dir_on ? sif.on_code : sif.off_code);
              if ((s_r.dir_on && s_nxt.grp == GRP_LAST) ||
                  (!s_r.dir_on && s_nxt.grp == GRP_FIRST)) begin
                s_nxt.state = ST_IDLE;
              end
            end else begin
              s_nxt.units = s_r.units - 5'h01;
            end
          end else begin
            s_nxt.tick = s_r.tick + 16'h0001;
          end
        end
        default: begin
          s_nxt.state = ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{state: ST_IDLE, dir_on: 1'b0, grp: 4'h0, step: 1'b0,
               units: 5'h00, tick: 16'h0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs to the controller
  assign sif.busy   = (s_r.state != ST_IDLE);
  assign sif.step   = s_r.step;
  assign sif.dir_on = s_r.dir_on;
  assign sif.grp    = s_r.grp;

endmodule : esq_group_stepper
`default_nettype wire

/* hdl/esq_enable_sequencer.sv */
// Overview of operation
// [R1] Select 0 follows sequencer, 1 follows software
// [R2] Bits 5:4 pick rail type A/U/S/SX
// [R3] Bits 3:0 group 0..14, 15 disables
// [R4] Wait type's group delay between consecutive indices
// [R5] Same per-type delay for every sequenced rail
// [R6] Power-up on and off delays are equal
// [R7] Timing bits 6:4 set turn-off delay code
// [R8] Timing bits 2:0 set turn-on delay code
// [R9] Control bit 1 selects, bit 0 software value
// [R10] Ascending on, descending off, disabled never toggled
// [R11] Reserved bits read zero, writes ignored
`default_nettype none
module esq_enable_sequencer
  import esq_pkg::*;
#(
  parameter int unsigned                   QMS_CYC  = QMS_CYCLES,
  parameter logic [NUM_OUT-1:0][7:0]       SLOT_OTP = {NUM_OUT{SLOT_RST}},
  parameter logic [NUM_TYPE-1:0][7:0]      TIM_OTP  = {NUM_TYPE{TIM_RST}}
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  // Power state machine requests
  input  wire logic               seq_on_req,
  input  wire logic               seq_off_req,
  output logic                    seq_busy,
  // Open-drain enable pins
  input  wire logic [NUM_OUT-1:0] en_pin_i,
  output logic      [NUM_OUT-1:0] en_pin_o,
  output logic      [NUM_OUT-1:0] en_pin_oe
);

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_r;

  // Release reset through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_OUT-1:0][5:0]  slot;      // Type and group per output
    logic [NUM_TYPE-1:0][5:0] tim;       // Off code above on code
    logic [NUM_OUT-1:0][1:0]  ctl;       // Select and software value
    logic [NUM_OUT-1:0]       seqc;      // Sequencer control per output
    logic [NUM_OUT-1:0]       pin_oe;
    logic [NUM_OUT-1:0]       pin_o;
    logic [NUM_OUT-1:0]       sync1;
    logic [NUM_OUT-1:0]       sync2;
    logic                     start_on;
    logic                     start_off;
    logic                     busy;
    logic [7:0]               rdata;
  } esq_state_t;

  // Power-up slots with reserved bits dropped
  function automatic logic [NUM_OUT-1:0][5:0] slot_init();
    logic [7:0] v;
    slot_init = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      v = SLOT_OTP[i] & SLOT_MASK;
      slot_init[i] = v[5:0];
    end
  endfunction

  // Power-up timing, off and on codes packed together
  function automatic logic [NUM_TYPE-1:0][5:0] tim_init();
    logic [7:0] v;
    tim_init = '0;
    for (int t = 0; t < NUM_TYPE; t++) begin
      v = TIM_OTP[t] & TIM_MASK;
      tim_init[t] = {v[OFF_MSB:OFF_LSB], v[ON_MSB:ON_LSB]};
    end
  endfunction

  localparam esq_state_t RST_VAL = '{slot: slot_init(), tim: tim_init(), default: '0};

  esq_state_t s_r;
  esq_state_t s_nxt;

  // ****************************************
  // Per-type group steppers
  // ****************************************
  logic [NUM_TYPE-1:0]      stp_busy;
  logic [NUM_TYPE-1:0]      stp_step;
  logic [NUM_TYPE-1:0]      stp_dir;
  logic [NUM_TYPE-1:0][3:0] stp_grp;

  esq_step_if sif [NUM_TYPE] ();

  // One stepper per rail type, shared by all rails of that type
  for (genvar t = 0; t < NUM_TYPE; t++) begin : g_type
    assign sif[t].start_on  = s_r.start_on;
    assign sif[t].start_off = s_r.start_off;
    assign sif[t].on_code   = s_r.tim[t][2:0];                    // R8
    assign sif[t].off_code  = s_r.tim[t][5:3];                    // R7
    assign stp_busy[t]      = sif[t].busy;
    assign stp_step[t]      = sif[t].step;
    assign stp_dir[t]       = sif[t].dir_on;
    assign stp_grp[t]       = sif[t].grp;

    esq_group_stepper #(
      .QMS_CYC (QMS_CYC)
    ) u_stepper (
      .clk_sys (clk_sys),
      .rst_n   (rst_sync_r),
      .sif     (sif[t])
    );
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [1:0] ty;
    logic [3:0] gi;
    logic       sel;
    ty    = 2'h0;
    gi    = 4'h0;
    sel   = 1'b0;
    s_nxt = s_r;

    // Pin level synchroniser
    s_nxt.sync1 = en_pin_i;
    s_nxt.sync2 = s_r.sync1;

    // Request pulses towards the steppers
    s_nxt.start_on  = seq_on_req;
    s_nxt.start_off = seq_off_req;
    s_nxt.busy      = |stp_busy;

    // Register writes, reserved bits dropped
    if (reg_wr) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (reg_addr == SLOT_ADDR[i]) begin
          s_nxt.slot[i] = reg_wdata[TYPE_MSB:GRP_LSB];            // R2 R3 R11
        end
        if (reg_addr == CTL_ADDR[i]) begin
          s_nxt.ctl[i] = reg_wdata[SEL_BIT:SWEN_BIT];              // R9 R11
        end
      end
      for (int t = 0; t < NUM_TYPE; t++) begin
        if (reg_addr == TIM_ADDR[t]) begin
          s_nxt.tim[t] = {reg_wdata[OFF_MSB:OFF_LSB],
                          reg_wdata[ON_MSB:ON_LSB]};               // R7 R8 R11
        end
      end
    end

    // Register reads, reserved bits as zero
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (reg_addr == SLOT_ADDR[i]) begin
          s_nxt.rdata = {2'h0, s_r.slot[i]};                       // R11
        end
        if (reg_addr == CTL_ADDR[i]) begin
          s_nxt.rdata = {6'h00, s_r.ctl[i]};
        end
      end
      for (int t = 0; t < NUM_TYPE; t++) begin
        if (reg_addr == TIM_ADDR[t]) begin
          s_nxt.rdata = {1'b0, s_r.tim[t][5:3], 1'b0, s_r.tim[t][2:0]}; // R11
        end
      end
      if (reg_addr == STAT_ADDR) begin
        s_nxt.rdata = {4'h0, stp_busy};
      end
      if (reg_addr == PINLO_ADDR) begin
        s_nxt.rdata = s_r.sync2[7:0];
      end
      if (reg_addr == PINHI_ADDR) begin
        s_nxt.rdata = {4'h0, s_r.sync2[NUM_OUT-1:8]};
      end
    end

    // Sequencer control: matching type stepper hits the output's group
    for (int i = 0; i < NUM_OUT; i++) begin
      ty = s_r.slot[i][TYPE_MSB:TYPE_LSB];                         // R2
      gi = s_r.slot[i][GRP_MSB:GRP_LSB];                           // R3
      if (stp_step[ty] && stp_grp[ty] == gi && gi != GRP_DISABLE) begin
        s_nxt.seqc[i] = stp_dir[ty];                               // R5 R10
      end
    end

    // Pin drive: low when the chosen control is 1, released when 0
    for (int i = 0; i < NUM_OUT; i++) begin
      sel = s_r.ctl[i][SEL_BIT];                                   // R9
      s_nxt.pin_oe[i] = sel ? s_r.ctl[i][SWEN_BIT] : s_r.seqc[i];  // R1
      s_nxt.pin_o[i]  = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_r <= RST_VAL;                                              // R6
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = s_r.rdata;
  assign seq_busy  = s_r.busy;
  assign en_pin_o  = s_r.pin_o;
  assign en_pin_oe = s_r.pin_oe;

endmodule : esq_enable_sequencer
`default_nettype wire

/* dv/esq_seq_props.sv */
`default_nettype none
module esq_seq_props
  import esq_pkg::*;
#(
  parameter int unsigned QMS_CYC = QMS_CYCLES
) (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // Register port
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_wdata,
  input wire logic [7:0]         reg_rdata,
  // Sequence control
  input wire logic               seq_on_req,
  input wire logic               seq_off_req,
  input wire logic               seq_busy,
  // Enable pins
  input wire logic [NUM_OUT-1:0] en_pin_i,
  input wire logic [NUM_OUT-1:0] en_pin_o,
  input wire logic [NUM_OUT-1:0] en_pin_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ****
  // Register port
  // ****
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_unmap_zero: assert property (reg_rd && reg_addr == 8'hFF |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_slot_rsvd: assert property (reg_rd && reg_addr inside {SLOT_ADDR} |=> !reg_rdata[7:6])
    else $error("slot reserved bits set");
  a_tim_rsvd: assert property (reg_rd && reg_addr inside {TIM_ADDR}
    |=> (reg_rdata & 8'h88) == 8'h00) else $error("timing reserved bits set");
  a_ctl_rsvd: assert property (reg_rd && reg_addr inside {CTL_ADDR}
    |=> (reg_rdata & 8'hFC) == 8'h00) else $error("control reserved bits set");
  a_slot_wrrd: assert property (reg_wr && reg_addr == SLOT_ADDR[0] ##2 reg_rd && !reg_wr
    && reg_addr == SLOT_ADDR[0] |=> reg_rdata == ($past(reg_wdata, 3) & SLOT_MASK))
    else $error("slot readback wrong");
  // ****
  // Pins and sequencing
  // ****
  a_od_low: assert property (en_pin_o == '0)
    else $error("open-drain data not low");
  a_ctl_force: assert property (reg_wr && reg_addr == CTL_ADDR[0] && reg_wdata[1]
    |-> ##2 en_pin_oe[0] == $past(reg_wdata[0], 2)) else $error("override not applied");
  a_req_busy: assert property ((seq_on_req || seq_off_req) && !seq_busy
    |-> ##[2:4] seq_busy) else $error("walk did not start");
  a_idle_hold: assert property ((!seq_busy && !reg_wr && !seq_on_req && !seq_off_req)[*4]
    |=> $stable(en_pin_oe)) else $error("pin moved while idle");
  // Main scenarios
  c_on_run: cover property (seq_on_req ##[2:4] seq_busy);
  c_off_run: cover property (seq_off_req ##[2:4] seq_busy);
  c_unmap: cover property (reg_rd && reg_addr == 8'hFF);
endmodule // esq_seq_props
bind esq_enable_sequencer esq_seq_props #(.QMS_CYC(QMS_CYC)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .seq_on_req(seq_on_req),
  .seq_off_req(seq_off_req), .seq_busy(seq_busy), .en_pin_i(en_pin_i),
  .en_pin_o(en_pin_o), .en_pin_oe(en_pin_oe));
`default_nettype wire

/* dv/esq_pin_load.sv */
`default_nettype none
module esq_pin_load
  import esq_pkg::*;
(
  // Driver side
  input wire logic [NUM_OUT-1:0] pin_o,
  input wire logic [NUM_OUT-1:0] pin_oe,
  // Line level
  output logic     [NUM_OUT-1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up wins unless the pin sinks
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_o[i] : 1'b1;
    end
  end
endmodule // esq_pin_load
`default_nettype wire

/* dv/enable_pin_group_sequencer_tb.sv */
`default_nettype none
module enable_pin_group_sequencer_tb
  import esq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned QC = 4;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               seq_on_req = 1'b0;
  logic               seq_off_req = 1'b0;
  logic [7:0]         reg_rdata;
  logic               seq_busy;
  logic [NUM_OUT-1:0] en_pin_i;
  logic [NUM_OUT-1:0] en_pin_o;
  logic [NUM_OUT-1:0] en_pin_oe;
  logic [NUM_OUT-1:0] oe_q = '0;
  logic [NUM_OUT-1:0] seqc_m = '0;
  logic [7:0]         mreg [256];
  logic [7:0]         mmsk [256];
  int                 error_cnt = 0;
  int                 checked = 0;
  int                 cyc = 0;
  int                 t_rise [NUM_OUT];
  int                 t_fall [NUM_OUT];
  int                 c [NUM_TYPE];
  int                 f [NUM_TYPE];
  logic [7:0]         sl [5] = '{8'h00, 8'h01, 8'h11, 8'h0F, 8'h2E};

  // Clock
  always #10 clk_sys = ~clk_sys;
  // Design, far-side load
  esq_enable_sequencer #(.QMS_CYC(QC)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .seq_on_req(seq_on_req), .seq_off_req(seq_off_req),
    .seq_busy(seq_busy), .en_pin_i(en_pin_i), .en_pin_o(en_pin_o), .en_pin_oe(en_pin_oe));
  esq_pin_load load_u (.pin_o(en_pin_o), .pin_oe(en_pin_oe), .pin_lvl(en_pin_i));
  // Edge times of every pin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    oe_q <= en_pin_oe;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (en_pin_oe[i] && !oe_q[i]) t_rise[i] = cyc;
      if (!en_pin_oe[i] && oe_q[i]) t_fall[i] = cyc;
    end
  end

  // ****
  // Tasks
  // ****
  function automatic int un(int k);
    return GRP_DLY_US[k] / QMS_US;
  endfunction
  task automatic cmp(string nm, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    mreg[a] = d & mmsk[a];
    @(negedge clk_sys);
  endtask
  task automatic rd_chk(logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    cmp("rdata", 16'(mreg[a]), 16'(reg_rdata));
    @(negedge clk_sys);
  endtask
  task automatic chk_pins();
    logic [NUM_OUT-1:0] e;
    @(negedge clk_sys);
    for (int i = 0; i < NUM_OUT; i++) begin
      e[i] = mreg[CTL_ADDR[i]][1] ? mreg[CTL_ADDR[i]][0] : seqc_m[i];
    end
    cmp("oe", 16'(e), 16'(en_pin_oe));
    cmp("o", 16'h0000, 16'(en_pin_o));
    // Line level seen back through the pull-up load
    mreg[PINLO_ADDR] = ~e[7:0];
    mreg[PINHI_ADDR] = {4'h0, ~e[NUM_OUT-1:8]};
  endtask
  task automatic seq(logic on);
    if (on) seq_on_req = 1'b1;
    else seq_off_req = 1'b1;
    @(negedge clk_sys);
    seq_on_req = 1'b0;
    seq_off_req = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (mreg[SLOT_ADDR[i]][3:0] != GRP_DISABLE) seqc_m[i] = on;
    end
    repeat (6) @(negedge clk_sys);
    for (int n = 0; n < 9000 && seq_busy !== 1'b0; n++) @(negedge clk_sys);
    cmp("busy", 16'h0000, 16'(seq_busy));
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    void'($urandom(4));
    foreach (mreg[a]) mreg[a] = 8'h00;
    foreach (mmsk[a]) mmsk[a] = 8'h00;
    for (int i = 0; i < NUM_OUT; i++) begin
      mreg[SLOT_ADDR[i]] = SLOT_RST;
      mmsk[SLOT_ADDR[i]] = SLOT_MASK;
      mmsk[CTL_ADDR[i]] = CTL_MASK;
    end
    for (int k = 0; k < NUM_TYPE; k++) begin
      mreg[TIM_ADDR[k]] = TIM_RST;
      mmsk[TIM_ADDR[k]] = TIM_MASK;
    end
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    // Power-up values, equal on and off codes
    for (int i = 0; i < NUM_OUT; i++) rd_chk(SLOT_ADDR[i]);
    for (int i = 0; i < NUM_OUT; i++) rd_chk(CTL_ADDR[i]);
    for (int k = 0; k < NUM_TYPE; k++) rd_chk(TIM_ADDR[k]);
    rd_chk(8'h00);
    rd_chk(8'hFF);
    $display("test reset values done");
    // Random writes, reserved bits dropped
    for (int i = 0; i < NUM_OUT; i++) begin
      wr(SLOT_ADDR[i], 8'($urandom));
      rd_chk(SLOT_ADDR[i]);
      wr(CTL_ADDR[i], 8'($urandom));
      rd_chk(CTL_ADDR[i]);
    end
    for (int k = 0; k < NUM_TYPE; k++) begin
      c[k] = $urandom_range(7);
      f[k] = $urandom_range(7);
      wr(TIM_ADDR[k], 8'($urandom) | 8'h88);
      rd_chk(TIM_ADDR[k]);
      wr(TIM_ADDR[k], 8'((f[k] << 4) | c[k]));
    end
    wr(8'hFF, 8'($urandom));
    rd_chk(8'hFF);
    chk_pins();
    $display("test register access done");
    // Turn-on walk across types
    for (int i = 0; i < NUM_OUT; i++) begin
      wr(SLOT_ADDR[i], i < 5 ? sl[i] : 8'h3F);
      wr(CTL_ADDR[i], 8'h00);
    end
    seq(1'b1);
    cmp("gap a on", 16'(un(c[0]) * QC), 16'(t_rise[1] - t_rise[0]));
    cmp("gap u on", 16'(un(c[1]) * QC), 16'(t_rise[2] - t_rise[0]));
    cmp("gap s on", 16'(14 * un(c[2]) * QC), 16'(t_rise[4] - t_rise[0]));
    chk_pins();
    rd_chk(PINLO_ADDR);
    rd_chk(PINHI_ADDR);
    rd_chk(STAT_ADDR);
    $display("test turn-on done");
    // Override table with sequencer on
    for (int v = 0; v < 4; v++) begin
      wr(CTL_ADDR[0], 8'(v));
      chk_pins();
    end
    wr(CTL_ADDR[0], 8'h00);
    $display("test override done");
    // Turn-off walk, descending
    seq(1'b0);
    cmp("gap a off", 16'(un(f[0]) * QC), 16'(t_fall[0] - t_fall[1]));
    cmp("gap s off", 16'(14 * un(f[0]) * QC), 16'(t_fall[0] - t_fall[4]));
    chk_pins();
    $display("test turn-off done");
    tally_and_finish();
  end
endmodule // enable_pin_group_sequencer_tb
`default_nettype wire
